// [design/sps_pkg.sv]
// Shared constants and types for the sensor power, command and host port slice.
package sps_pkg;
    // Device register map, 7-bit serial addresses.
    localparam logic [6:0] ADDR_NV      = 7'h70;
    localparam logic [6:0] ADDR_IFCFG   = 7'h6A;
    localparam logic [6:0] ADDR_AUXDAT  = 7'h6C;
    localparam logic [6:0] ADDR_SENSOR  = 7'h7D;
    localparam logic [6:0] ADDR_CMD     = 7'h7E;
    // Field positions, masks and reset values.
    localparam int         SENS_ACC_BIT = 2;
    localparam int         SENS_AUX_BIT = 0;
    localparam logic [7:0] SENS_MASK    = 8'h05;
    localparam logic [7:0] SENS_RESET   = 8'h00;
    localparam int         NV_SPI_BIT   = 0;
    localparam logic [7:0] NV_MASK      = 8'h0F;
    localparam logic [7:0] NV_RESET     = 8'h00;
    localparam int         CFG_3W_BIT   = 0;
    localparam logic [7:0] CFG_MASK     = 8'h07;
    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] CMD_READ     = 8'h00;
    // Command codes.
    localparam logic [7:0] CMD_NVM_PROG = 8'hA0;
    localparam logic [7:0] CMD_FLUSH    = 8'hB0;
    localparam logic [7:0] CMD_SOFTRST  = 8'hB6;
    // Timing: clock period and serial clock half period.
    localparam int         CLK_NS       = 25;
    localparam int         SCK_HALF_NS  = 100;
    localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] AUX_PERIOD   = 8'h3F;
    // Host register map, byte addresses on APB.
    localparam logic [7:0] HOFS_CTRL    = 8'h00;
    localparam logic [7:0] HOFS_MODE    = 8'h04;
    localparam logic [7:0] HOFS_STATUS  = 8'h08;
    localparam int         CTRL_RD_BIT  = 15;
    typedef enum logic [1:0] {SPS_IDLE, SPS_SETUP, SPS_SHIFT, SPS_HOLD} sps_hstate_t;
endpackage

// [design/sps_link_if.sv]
// Pin-level link between the sensor end and the processor end.
interface sps_link_if;
    logic       chip_select_n;
    logic       shared_clock_pin;
    logic       host_sdx_o;
    logic       host_sdx_oe;
    logic       dev_sdx_o;
    logic       dev_sdx_oe;
    logic       dev_sdo_o;
    logic       dev_sdo_oe;
    logic       host_sdo_o;
    logic       host_sdo_oe;
    logic [1:0] dev_ev_o;
    logic [1:0] dev_ev_oe;
    logic [1:0] host_ev_o;
    logic [1:0] host_ev_oe;
    logic       shared_data_pin;
    logic       sdo_pin;
    logic [1:0] event_pin;
    // Wire levels: data line pulled up, strap pin pulled down, event lines low when idle.
    assign shared_data_pin = dev_sdx_oe ? dev_sdx_o : (host_sdx_oe ? host_sdx_o : 1'b1);
    assign sdo_pin = dev_sdo_oe ? dev_sdo_o : (host_sdo_oe & host_sdo_o);
    assign event_pin = (dev_ev_oe & dev_ev_o) | (~dev_ev_oe & host_ev_oe & host_ev_o);
    modport dev (input chip_select_n, shared_clock_pin, shared_data_pin, sdo_pin, event_pin,
                 output dev_sdx_o, dev_sdx_oe, dev_sdo_o, dev_sdo_oe, dev_ev_o, dev_ev_oe);
    modport host (output chip_select_n, shared_clock_pin, host_sdx_o, host_sdx_oe,
                  host_sdo_o, host_sdo_oe, host_ev_o, host_ev_oe,
                  input shared_data_pin, sdo_pin, event_pin);
endinterface

// [design/sps_dev.sv]
// Sensor end: serial slave port, sensor enable, command entry and auxiliary fetch.
//
// The APB slave port was left to the implementer.

// Notes on behaviour
// RULE1: enable register resets zero, bits two, zero.
// RULE2: auxiliary bit turns auxiliary path off/on.
// RULE3: command register always reads zero.
// RULE4: code A0 stores persistent registers.
// RULE5: code B0 flushes queue, settings kept.
// RULE6: code B6 restores all user defaults.
// RULE7: primary port is slave; processor masters.
// RULE8: sensor masters the auxiliary external sensor.
// RULE9: auxiliary data fetched alone, readable by host.
// RULE10: primary port starts in I2C mode.
// RULE11: four-line serial slave with separate lines.
// RULE12: software may select single shared data line.
// RULE13: output pin drives, straps, or idles.
// RULE14: shared data pin role per mode.
// RULE15: chip select frames serial transfers.
// RULE16: shared clock pin always host driven.
// RULE17: event pins outputs, optionally sync inputs.
// RULE18: chip select rising edge selects serial mode.
// RULE19: persistent bit forces serial mode.
// RULE20: unknown command codes change nothing.
// RULE21: reserved enable bits ignored, read zero.
module sps_dev (
    input  wire logic       pclk,
    input  wire logic       presetn,
    sps_link_if.dev         lnk,
    input  wire logic [1:0] event_src,
    input  wire logic       aux_ack,
    input  wire logic [7:0] aux_data,
    output logic            accel_on,
    output logic            aux_on,
    output logic            queue_flush,
    output logic            nvm_prog,
    output logic            aux_fetch,
    output logic [1:0]      sync_mark,
    output logic            addr_sel,
    output logic            serial_mode
);
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic       csn_d_r;
    logic       sck_d_r;
    logic       spi_mode_r;
    logic       soft_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic       rw_r;
    logic [6:0] addr_r;
    logic       wr_stb_r;
    logic [6:0] wr_addr_r;
    logic [7:0] wr_data_r;
    logic [7:0] sens_r;
    logic [7:0] nv_r;
    logic [7:0] nvm_r;
    logic [7:0] cfg_r;
    logic [7:0] aux_r;
    logic [7:0] aux_cnt_r;
    logic       sdo_o_r;
    logic       sdo_oe_r;
    logic       sdx_o_r;
    logic       sdx_oe_r;
    logic [1:0] ev_o_r;
    logic [1:0] ev_oe_r;
    logic       flush_r;
    logic       prog_r;
    logic       fetch_r;
    logic [1:0] sync_r;
    logic       addr_sel_r;
    logic [5:0] pin_raw;
    logic       csn_s;
    logic       sck_s;
    logic       din_s;
    logic       sdo_s;
    logic [1:0] ev_s;
    logic       spi_act;
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] rdata;
    logic [7:0] rx_byte;

    assign pin_raw = {lnk.event_pin, lnk.sdo_pin, lnk.shared_data_pin,
                      lnk.shared_clock_pin, lnk.chip_select_n};

    // Two-stage synchronisers for every pin entering from the link.
    for (genvar i = 0; i < 6; i++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_s1_r[i] <= 1'b1;
                pin_s2_r[i] <= 1'b1;
            end else begin
                pin_s1_r[i] <= pin_raw[i];
                pin_s2_r[i] <= pin_s1_r[i];
            end
        end
    end

    assign csn_s = pin_s2_r[0];
    assign sck_s = pin_s2_r[1];
    assign din_s = pin_s2_r[2];
    assign sdo_s = pin_s2_r[3];
    assign ev_s  = pin_s2_r[4 +: 2] & 2'h3;
    assign spi_act  = spi_mode_r | nv_r[sps_pkg::NV_SPI_BIT];      // see RULE19
    assign sck_rise = spi_act & ~csn_s & sck_s & ~sck_d_r;          // see RULE16
    assign sck_fall = spi_act & ~csn_s & ~sck_s & sck_d_r;
    assign rx_byte  = {shift_r[6:0], din_s};

    // Read data per address; the command register never shows what was written.
    always_comb begin
        unique case (addr_r)
            sps_pkg::ADDR_SENSOR: rdata = sens_r & sps_pkg::SENS_MASK;   // see RULE21
            sps_pkg::ADDR_CMD:    rdata = sps_pkg::CMD_READ;             // see RULE3
            sps_pkg::ADDR_NV:     rdata = nv_r;
            sps_pkg::ADDR_IFCFG:  rdata = cfg_r;
            sps_pkg::ADDR_AUXDAT: rdata = aux_r;                         // see RULE9
            default:              rdata = 8'h00;
        endcase
    end

    // Edge history of the synchronised chip select and clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csn_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            csn_d_r <= csn_s;
            sck_d_r <= sck_s;
        end
    end

    // Mode latch: I2C after reset, serial after the first chip select rise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_mode_r <= 1'b0;                                      // see RULE10
        end else if (soft_r) begin
            spi_mode_r <= 1'b0;
        end else if (csn_s && !csn_d_r) begin
            spi_mode_r <= 1'b1;                                      // see RULE18
        end
    end

    // Serial slave: header byte, then data bytes with address auto-increment.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r     <= 4'h0;
            shift_r   <= 8'h00;
            rw_r      <= 1'b0;
            addr_r    <= 7'h00;
            wr_stb_r  <= 1'b0;
            wr_addr_r <= 7'h00;
            wr_data_r <= 8'h00;
        end else begin
            wr_stb_r <= 1'b0;
            if (csn_s) begin
                cnt_r <= 4'h0;                                       // see RULE15
            end else if (sck_rise) begin
                shift_r <= rx_byte;                                  // see RULE7
                cnt_r   <= (cnt_r == 4'hF) ? 4'h8 : cnt_r + 4'h1;
                if (cnt_r == 4'h7) begin
                    rw_r   <= rx_byte[7];
                    addr_r <= rx_byte[6:0];
                end
                if (cnt_r == 4'hF) begin
                    wr_stb_r  <= ~rw_r;
                    wr_addr_r <= addr_r;
                    wr_data_r <= rx_byte;
                    addr_r    <= addr_r + 7'h01;
                end
            end
        end
    end

    // Read data driver: the output pin in four-line mode, the shared pin in three-line mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_o_r  <= 1'b0;
            sdo_oe_r <= 1'b0;
            sdx_o_r  <= 1'b0;
            sdx_oe_r <= 1'b0;
        end else if (csn_s || !spi_act) begin
            sdo_oe_r <= 1'b0;                                        // see RULE13
            sdx_oe_r <= 1'b0;
        end else if (sck_fall && cnt_r[3] && rw_r) begin
            sdo_o_r  <= rdata[~cnt_r[2:0]];                          // see RULE11
            sdx_o_r  <= rdata[~cnt_r[2:0]];
            sdo_oe_r <= ~cfg_r[sps_pkg::CFG_3W_BIT];
            sdx_oe_r <= cfg_r[sps_pkg::CFG_3W_BIT];                  // see RULE12, RULE14
        end
    end

    // Register writes and command execution.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sens_r  <= sps_pkg::SENS_RESET;                          // see RULE1
            nv_r    <= sps_pkg::NV_RESET;
            nvm_r   <= sps_pkg::NV_RESET;
            cfg_r   <= sps_pkg::CFG_RESET;
            soft_r  <= 1'b0;
            flush_r <= 1'b0;
            prog_r  <= 1'b0;
        end else begin
            soft_r  <= 1'b0;
            flush_r <= 1'b0;
            prog_r  <= 1'b0;
            if (soft_r) begin
                sens_r <= sps_pkg::SENS_RESET;                       // see RULE6
                cfg_r  <= sps_pkg::CFG_RESET;
                nv_r   <= nvm_r;
            end else if (wr_stb_r) begin
                unique case (wr_addr_r)
                    sps_pkg::ADDR_SENSOR: sens_r <= wr_data_r & sps_pkg::SENS_MASK; // see RULE2
                    sps_pkg::ADDR_NV:     nv_r   <= wr_data_r & sps_pkg::NV_MASK;
                    sps_pkg::ADDR_IFCFG:  cfg_r  <= wr_data_r & sps_pkg::CFG_MASK;
                    sps_pkg::ADDR_CMD: begin
                        unique case (wr_data_r)
                            sps_pkg::CMD_NVM_PROG: begin
                                nvm_r  <= nv_r;                      // see RULE4
                                prog_r <= 1'b1;
                            end
                            sps_pkg::CMD_FLUSH:   flush_r <= 1'b1;   // see RULE5
                            sps_pkg::CMD_SOFTRST: soft_r  <= 1'b1;
                            default: ;                               // see RULE20
                        endcase
                    end
                    default: ;
                endcase
            end
        end
    end

    // Auxiliary master: periodic fetch while enabled, result kept for the host.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_cnt_r <= 8'h00;
            fetch_r   <= 1'b0;
            aux_r     <= 8'h00;
        end else begin
            fetch_r <= 1'b0;
            if (!sens_r[sps_pkg::SENS_AUX_BIT]) begin
                aux_cnt_r <= 8'h00;                                  // see RULE2
            end else if (aux_cnt_r == 8'h00) begin
                aux_cnt_r <= sps_pkg::AUX_PERIOD;
                fetch_r   <= 1'b1;                                   // see RULE8
            end else begin
                aux_cnt_r <= aux_cnt_r - 8'h01;
            end
            if (aux_ack) begin
                aux_r <= aux_data;                                   // see RULE9
            end
        end
    end

    // Event pins, address strap and level outputs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_o_r     <= 2'h0;
            ev_oe_r    <= 2'h3;
            sync_r     <= 2'h0;
            addr_sel_r <= 1'b0;
        end else begin
            ev_o_r  <= event_src;
            ev_oe_r <= ~cfg_r[2:1];                                  // see RULE17
            sync_r  <= ev_s & cfg_r[2:1];
            if (!spi_act) begin
                addr_sel_r <= sdo_s;                                 // see RULE13
            end
        end
    end

    assign lnk.dev_sdo_o  = sdo_o_r;
    assign lnk.dev_sdo_oe = sdo_oe_r;
    assign lnk.dev_sdx_o  = sdx_o_r;
    assign lnk.dev_sdx_oe = sdx_oe_r;
    assign lnk.dev_ev_o   = ev_o_r;
    assign lnk.dev_ev_oe  = ev_oe_r;
    assign accel_on    = sens_r[sps_pkg::SENS_ACC_BIT];
    assign aux_on      = sens_r[sps_pkg::SENS_AUX_BIT];
    assign queue_flush = flush_r;
    assign nvm_prog    = prog_r;
    assign aux_fetch   = fetch_r;
    assign sync_mark   = sync_r;
    assign addr_sel    = addr_sel_r;
    assign serial_mode = spi_mode_r;
endmodule

// [design/sps_host.sv]
// Processor end: APB registers driving single-byte serial transfers to the sensor.
module sps_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    sps_link_if.host         lnk
);
    sps_pkg::sps_hstate_t st_r;
    logic [3:0]  div_r;
    logic [3:0]  bit_r;
    logic [15:0] tx_r;
    logic [7:0]  rx_r;
    logic        csn_r;
    logic        sck_r;
    logic        sdx_o_r;
    logic        sdx_oe_r;
    logic [6:0]  mode_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [3:0]  s1_r;
    logic [3:0]  s2_r;
    logic        tick;
    logic        din;
    logic        setup;
    logic        go;
    logic        rd_r;

    assign setup = psel & ~penable & ~pready_r;
    assign go    = setup & pwrite & (paddr == sps_pkg::HOFS_CTRL) & (st_r == sps_pkg::SPS_IDLE);
    assign tick  = (div_r == 4'h0);
    assign din   = mode_r[0] ? s2_r[0] : s2_r[1];

    // Pin synchronisers for returned data and event lines.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else begin
            s1_r <= {lnk.event_pin, lnk.sdo_pin, lnk.shared_data_pin};
            s2_r <= s1_r;
        end
    end

    // APB slave: answer in the cycle after setup, register writes at that edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            mode_r    <= 7'h00;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & (paddr != sps_pkg::HOFS_CTRL) & (paddr != sps_pkg::HOFS_MODE)
                         & (paddr != sps_pkg::HOFS_STATUS);
            if (setup && pwrite && paddr == sps_pkg::HOFS_MODE) begin
                mode_r <= pwdata[6:0];
            end
            unique case (paddr)
                sps_pkg::HOFS_MODE:   prdata_r <= {25'h0, mode_r};
                sps_pkg::HOFS_STATUS: prdata_r <= {14'h0, s2_r[3:2], rx_r, 7'h0,
                                                   st_r != sps_pkg::SPS_IDLE};
                default:              prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Serial master: chip select framing, clock from the divider, 16 bits per frame.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= sps_pkg::SPS_IDLE;
            div_r    <= 4'h0;
            bit_r    <= 4'h0;
            tx_r     <= 16'h0000;
            rx_r     <= 8'h00;
            csn_r    <= 1'b1;
            sck_r    <= 1'b0;
            sdx_o_r  <= 1'b1;
            sdx_oe_r <= 1'b0;
        end else begin
            div_r <= tick ? sps_pkg::SCK_HALF_CYC - 4'h1 : div_r - 4'h1;
            unique case (st_r)
                sps_pkg::SPS_IDLE: begin
                    if (go) begin
                        tx_r     <= pwdata[15:0];
                        csn_r    <= 1'b0;
                        sdx_o_r  <= pwdata[15];
                        sdx_oe_r <= 1'b1;
                        bit_r    <= 4'h0;
                        div_r    <= sps_pkg::SCK_HALF_CYC - 4'h1;
                        st_r     <= sps_pkg::SPS_SETUP;
                    end
                end
                sps_pkg::SPS_SETUP: if (tick) st_r <= sps_pkg::SPS_SHIFT;
                sps_pkg::SPS_SHIFT: begin
                    if (tick && !sck_r) begin
                        sck_r <= 1'b1;
                    end else if (tick) begin
                        sck_r <= 1'b0;
                        if (bit_r[3]) rx_r <= {rx_r[6:0], din};
                        bit_r <= bit_r + 4'h1;
                        tx_r  <= {tx_r[14:0], 1'b0};
                        sdx_o_r <= tx_r[14];
                        // Three-line reads hand the data line to the sensor for the data byte.
                        sdx_oe_r <= ~(mode_r[0] & rd_r & (bit_r >= 4'h7));
                        if (bit_r == 4'hF) st_r <= sps_pkg::SPS_HOLD;
                    end
                end
                sps_pkg::SPS_HOLD: begin
                    if (tick) begin
                        csn_r    <= 1'b1;
                        sdx_oe_r <= 1'b0;
                        st_r     <= sps_pkg::SPS_IDLE;
                    end
                end
            endcase
        end
    end

    // Read flag of the frame in flight, kept from the header as it shifts out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_r <= 1'b0;
        end else if (go) begin
            rd_r <= pwdata[sps_pkg::CTRL_RD_BIT];
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign lnk.chip_select_n    = csn_r;
    assign lnk.shared_clock_pin = sck_r;
    assign lnk.host_sdx_o   = sdx_o_r;
    assign lnk.host_sdx_oe  = sdx_oe_r;
    assign lnk.host_sdo_o   = mode_r[2];
    assign lnk.host_sdo_oe  = mode_r[1];
    assign lnk.host_ev_o    = mode_r[6:5];
    assign lnk.host_ev_oe   = mode_r[4:3];
endmodule

// [dv/sps_assertions.sv]
// Timing checks on the sensor link and on the sensor end's user outputs.
module sps_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       chip_select_n,
    input wire logic       shared_clock_pin,
    input wire logic       dev_sdx_oe,
    input wire logic       host_sdx_oe,
    input wire logic       dev_sdo_oe,
    input wire logic [1:0] dev_ev_oe,
    input wire logic       queue_flush,
    input wire logic       nvm_prog,
    input wire logic       aux_fetch,
    input wire logic       aux_on,
    input wire logic       serial_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A frame opens with the serial clock held low for at least one half period.
    sequence s_lead;
        !shared_clock_pin [*4];
    endsequence
    // Pulses from the command entry last one cycle.
    sequence s_gap;
        !queue_flush && !nvm_prog;
    endsequence
    // Each check ties a link or user signal to its cause.
    a_frame_lead: assert property ($fell(chip_select_n) |-> s_lead)
        else $error("serial clock moved during frame lead-in");
    a_clock_idle: assert property (chip_select_n |-> !shared_clock_pin)
        else $error("serial clock active outside a frame");
    a_select_latch: assert property ($rose(chip_select_n) |-> ##[1:4] serial_mode)
        else $error("chip select rise did not select serial mode");
    a_flush_once: assert property (queue_flush |-> !chip_select_n ##1 s_gap)
        else $error("flush pulse outside a frame or too long");
    a_store_once: assert property (nvm_prog |-> !chip_select_n ##1 s_gap)
        else $error("store pulse outside a frame or too long");
    a_out_quiet: assert property (dev_sdo_oe |-> serial_mode)
        else $error("output pin driven outside serial mode");
    a_data_clash: assert property (!(dev_sdx_oe && host_sdx_oe))
        else $error("both ends drive the shared data pin");
    a_fetch_gap: assert property (aux_fetch |-> $past(aux_on) ##1 !aux_fetch [*8])
        else $error("auxiliary fetch while disabled or too soon");
    a_event_out: assert property ($rose(presetn) |-> dev_ev_oe == 2'h3)
        else $error("event pins not outputs after reset");
endmodule

// [dv/sensor_power_command_host_port_test.sv]
// Testbench joining both ends and driving the processor end over APB.
module sensor_power_command_host_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, aux_ack, err;
    logic        accel_on, aux_on, queue_flush, nvm_prog, aux_fetch, addr_sel, serial_mode;
    logic [7:0]  paddr, aux_data;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  event_src, sync_mark;
    logic [7:0]  codes [3] = '{sps_pkg::CMD_NVM_PROG, sps_pkg::CMD_FLUSH, 8'h3C};
    int          fails, n_compared, n_flush, n_prog;
    sps_link_if lnk ();
    sps_dev u_sps_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk), .event_src(event_src),
        .aux_ack(aux_ack), .aux_data(aux_data), .accel_on(accel_on), .aux_on(aux_on),
        .queue_flush(queue_flush), .nvm_prog(nvm_prog), .aux_fetch(aux_fetch),
        .sync_mark(sync_mark), .addr_sel(addr_sel), .serial_mode(serial_mode));
    sps_host u_sps_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk));
    sps_assertions u_chk (.pclk(pclk), .presetn(presetn), .chip_select_n(lnk.chip_select_n),
        .shared_clock_pin(lnk.shared_clock_pin), .dev_sdx_oe(lnk.dev_sdx_oe),
        .host_sdx_oe(lnk.host_sdx_oe), .dev_sdo_oe(lnk.dev_sdo_oe), .dev_ev_oe(lnk.dev_ev_oe),
        .queue_flush(queue_flush), .nvm_prog(nvm_prog), .aux_fetch(aux_fetch),
        .aux_on(aux_on), .serial_mode(serial_mode));
    // Clock of 25 ns period.
    always #12.5 pclk = ~pclk;
    // Counts command pulses and answers each auxiliary fetch with a byte.
    always @(posedge pclk) begin
        n_flush <= n_flush + int'(queue_flush);
        n_prog <= n_prog + int'(nvm_prog);
        aux_ack <= aux_fetch;
        aux_data <= 8'hC3;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Compares a seen byte with the expected one.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; result lands in q and err.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50) begin
            fails++;
            give_verdict();
        end
    endtask
    // One serial frame to the sensor, then polls until the host is idle.
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, sps_pkg::HOFS_CTRL, {16'h0000, rd, a, d});
        n = 0;
        do begin
            apb(1'b0, sps_pkg::HOFS_STATUS, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 100);
        if (n >= 100) begin
            fails++;
            give_verdict();
        end
    endtask
    // Main sequence.
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {fails, n_compared, n_flush, n_prog} = '0;
        event_src = 2'h1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({6'h00, accel_on, aux_on}, 8'h00);
        chk({7'h00, serial_mode}, 8'h00);
        apb(1'b1, sps_pkg::HOFS_MODE, 32'h6);
        repeat (4) @(posedge pclk);
        chk({7'h00, addr_sel}, 8'h01);
        apb(1'b1, sps_pkg::HOFS_MODE, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk({7'h00, err}, 8'h01);
        xfer(1'b1, sps_pkg::ADDR_SENSOR, 8'h00);
        chk({7'h00, serial_mode}, 8'h01);
        xfer(1'b0, sps_pkg::ADDR_SENSOR, 8'hFF);
        xfer(1'b1, sps_pkg::ADDR_SENSOR, 8'h00);
        chk(q[15:8], sps_pkg::SENS_MASK);
        chk({6'h00, accel_on, aux_on}, 8'h03);
        xfer(1'b1, sps_pkg::ADDR_AUXDAT, 8'h00);
        chk(q[15:8], 8'hC3);
        xfer(1'b0, sps_pkg::ADDR_SENSOR, 8'h04);
        chk({6'h00, accel_on, aux_on}, 8'h02);
        xfer(1'b0, sps_pkg::ADDR_NV, 8'h01);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, sps_pkg::ADDR_CMD, codes[i]);
            xfer(1'b1, sps_pkg::ADDR_CMD, 8'h00);
            chk(q[15:8], sps_pkg::CMD_READ);
        end
        chk(n_prog[7:0], 8'h01);
        chk(n_flush[7:0], 8'h01);
        xfer(1'b1, sps_pkg::ADDR_SENSOR, 8'h00);
        chk(q[15:8], 8'h04);
        xfer(1'b0, sps_pkg::ADDR_IFCFG, 8'h06);
        apb(1'b1, sps_pkg::HOFS_MODE, 32'h58);
        repeat (4) @(posedge pclk);
        chk({6'h00, sync_mark}, 8'h02);
        apb(1'b0, sps_pkg::HOFS_MODE, 32'h0);
        chk(q[7:0], 8'h58);
        xfer(1'b0, sps_pkg::ADDR_IFCFG, 8'h01);
        apb(1'b1, sps_pkg::HOFS_MODE, 32'h1);
        apb(1'b0, sps_pkg::HOFS_STATUS, 32'h0);
        chk({6'h00, q[17:16]}, 8'h01);
        xfer(1'b1, sps_pkg::ADDR_SENSOR, 8'h00);
        chk(q[15:8], 8'h04);
        xfer(1'b0, sps_pkg::ADDR_CMD, sps_pkg::CMD_SOFTRST);
        chk({6'h00, accel_on, aux_on}, 8'h00);
        apb(1'b1, sps_pkg::HOFS_MODE, 32'h0);
        xfer(1'b1, sps_pkg::ADDR_SENSOR, 8'h00);
        xfer(1'b1, sps_pkg::ADDR_IFCFG, 8'h00);
        chk(q[15:8], sps_pkg::CFG_RESET);
        xfer(1'b1, sps_pkg::ADDR_NV, 8'h00);
        chk(q[15:8], 8'h01);
        give_verdict();
    end
endmodule
